// ===== rtl/chpx_pkg.sv
// Shared constants and types for the channel phasing and read crossing block.
package chpx_pkg;
   localparam int unsigned MCLK_HZ = 20_000_000;
   localparam int BYTE_W = 9;
   localparam int ROW_W = 3;
   localparam int COL_W = 5;
   localparam int ID_W = 6;
   localparam int WORD_W = 2 * BYTE_W;
   localparam int LAT_W = 4;
   localparam int CNT_W = 5;
   localparam int HALF_W = 6;
   localparam int QDEPTH = 4;
   localparam int QPTR_W = 2;
   localparam int SYNC_W = 5 + 2 * BYTE_W + ROW_W + COL_W;
   // Positions inside the synchroniser bundle.
   localparam int S_TXCLK = 0;
   localparam int S_RXCLK = 1;
   localparam int S_SCK = 2;
   localparam int S_CMD = 3;
   localparam int S_SERIAL_CHAIN_PORT_SECOND = 4;
   localparam int S_A = 5;
   localparam int S_B = S_A + BYTE_W;
   localparam int S_ROW = S_B + BYTE_W;
   localparam int S_COL = S_ROW + ROW_W;
   // Read latency limits and reset values; latencies in channel clock cycles, the half-period reset in master clock cycles.
   localparam logic [LAT_W-1:0] LAT_MIN = 4'h8;
   localparam logic [LAT_W-1:0] LAT_MAX = 4'hc;
   localparam logic [LAT_W-1:0] LAT_RESET = 4'h8;
   localparam logic [1:0] ADJ_NOMINAL = 2'h0;
   localparam logic [1:0] ADJ_EARLY = 2'h1;
   localparam logic [1:0] ADJ_LATE = 2'h2;
   localparam logic [HALF_W-1:0] HALF_RESET = 6'h04;
   localparam logic [ID_W-1:0] DEV_ID_RESET = 6'h00;
   typedef enum logic [1:0] {
      CHPX_CFG_OPEN = 2'b01,
      CHPX_CFG_LOCKED = 2'b10
   } chpx_cfg_e;
   typedef enum logic [4:0] {
      CHPX_TX_IDLE = 5'b00001,
      CHPX_TX_EVEN_WAIT = 5'b00010,
      CHPX_TX_ODD_WAIT = 5'b00100,
      CHPX_TX_ODD_DLY = 5'b01000,
      CHPX_TX_ODD_HOLD = 5'b10000
   } chpx_tx_e;
endpackage : chpx_pkg

// ===== rtl/chpx_sync.sv
// Two-flop synchroniser bank with a third stage for edge detection.
module chpx_sync #(
   parameter int W = 1
) (
   // Clocking
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] q_d
);
   logic [W-1:0] meta;

   // The first stage feeds only the second; edges are taken from stages two and three.
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
         q_d <= '0;
      end else if (ce) begin
         meta <= d;
         q <= meta;
         q_d <= q;
      end
   end
endmodule : chpx_sync

// ===== rtl/chpx_top.sv
// Channel phasing, serial control port and read data domain crossing.
// Operation
// - Transmit on transmit clock, receive on receive clock.
// - Capture every channel line twice per cycle.
// - Capture points at falling and rising receive edges.
// - Even bit 75%-25%, odd bit 25%-75%.
// - Controller makes serial clock; signals active high.
// - Command sampled rising (odd) and falling (even).
// - Serial data input sampled on falling edge.
// - Serial read output changes on falling edge.
// - Chain passes first-to-second, read data back.
// - Broadcast select wakes every sleeping device.
// - Otherwise only the addressed sleeping device wakes.
// - Read data crosses clocks for any phase.
// - Read data after latency minus phase offset.
// - Optional one cycle earlier for small offsets.
// - Optional one cycle later for large offsets.
// - Delay choice fixed at initialization.
// - Read latency programmable from 8 to 12.
module chpx_top (
   // Clocking
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Channel clocks
   input wire logic transmit_clock_true,
   input wire logic receive_clock_true,
   // Channel buses
   input wire logic [chpx_pkg::BYTE_W-1:0] data_byte_bus_a_in,
   output logic [chpx_pkg::BYTE_W-1:0] data_byte_bus_a_out,
   input wire logic [chpx_pkg::BYTE_W-1:0] data_byte_bus_b_in,
   output logic [chpx_pkg::BYTE_W-1:0] data_byte_bus_b_out,
   output logic data_bus_oe,
   input wire logic [chpx_pkg::ROW_W-1:0] row_bus,
   input wire logic [chpx_pkg::COL_W-1:0] col_bus,
   // Captured channel pairs
   output logic [chpx_pkg::WORD_W-1:0] rx_data_even,
   output logic [chpx_pkg::WORD_W-1:0] rx_data_odd,
   output logic [2*(chpx_pkg::ROW_W+chpx_pkg::COL_W)-1:0] rx_req_pair,
   output logic rx_pair_valid,
   // Read returns from the core
   input wire logic rd_cmd,
   input wire logic [chpx_pkg::WORD_W-1:0] rd_even,
   input wire logic [chpx_pkg::WORD_W-1:0] rd_odd,
   // Initialization
   input wire logic cfg_load,
   input wire logic [chpx_pkg::LAT_W-1:0] cfg_latency,
   input wire logic [1:0] cfg_adjust,
   output logic cfg_locked,
   // Serial control port
   input wire logic serial_clock,
   input wire logic serial_cmd,
   input wire logic serial_chain_port_first_in,
   output logic serial_chain_port_first_out,
   output logic serial_chain_port_first_oe,
   input wire logic serial_chain_port_second_in,
   output logic serial_chain_port_second_out,
   output logic serial_chain_port_second_oe,
   input wire logic sio_read_phase,
   input wire logic sio_tx_bit,
   input wire logic sio_tx_en,
   output logic [1:0] serial_cmd_bits,
   output logic serial_cmd_valid,
   output logic sio_rx_bit,
   output logic sio_rx_valid,
   // Power state wake-up
   input wire logic light_sleep_state,
   input wire logic deep_powerdown_state,
   input wire logic broadcast_wake_select,
   input wire logic [chpx_pkg::ID_W-1:0] device_id_strap,
   output logic wake_start
);
   logic [chpx_pkg::SYNC_W-1:0] s_q;
   logic [chpx_pkg::SYNC_W-1:0] s_qd;
   logic tx_rise, tx_fall, rx_rise, rx_fall, sck_rise, sck_fall;
   logic [chpx_pkg::BYTE_W-1:0] bus_a, bus_b;
   logic [chpx_pkg::ROW_W-1:0] row_s;
   logic [chpx_pkg::COL_W-1:0] col_s;
   logic cmd_s, first_s, second_s, asleep;

   // The first serial pin has its own pair of flops; only the second of them is read.
   logic first_meta, first_sync;

   chpx_sync #(.W(chpx_pkg::SYNC_W)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .d({col_bus, row_bus, data_byte_bus_b_in, data_byte_bus_a_in, serial_chain_port_second_in,
          serial_cmd, serial_clock, receive_clock_true, transmit_clock_true}),
      .q(s_q),
      .q_d(s_qd)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         first_meta <= 1'b0;
         first_sync <= 1'b0;
      end else if (ce) begin
         first_meta <= serial_chain_port_first_in;
         first_sync <= first_meta;
      end
   end

   assign tx_rise = s_q[chpx_pkg::S_TXCLK] & ~s_qd[chpx_pkg::S_TXCLK];
   assign tx_fall = ~s_q[chpx_pkg::S_TXCLK] & s_qd[chpx_pkg::S_TXCLK];
   assign rx_rise = s_q[chpx_pkg::S_RXCLK] & ~s_qd[chpx_pkg::S_RXCLK];
   assign rx_fall = ~s_q[chpx_pkg::S_RXCLK] & s_qd[chpx_pkg::S_RXCLK];
   assign sck_rise = s_q[chpx_pkg::S_SCK] & ~s_qd[chpx_pkg::S_SCK];
   assign sck_fall = ~s_q[chpx_pkg::S_SCK] & s_qd[chpx_pkg::S_SCK];
   assign cmd_s = s_q[chpx_pkg::S_CMD];
   assign second_s = s_q[chpx_pkg::S_SERIAL_CHAIN_PORT_SECOND];
   assign first_s = first_sync;
   assign bus_a = s_q[chpx_pkg::S_A +: chpx_pkg::BYTE_W];
   assign bus_b = s_q[chpx_pkg::S_B +: chpx_pkg::BYTE_W];
   assign row_s = s_q[chpx_pkg::S_ROW +: chpx_pkg::ROW_W];
   assign col_s = s_q[chpx_pkg::S_COL +: chpx_pkg::COL_W];
   assign asleep = light_sleep_state | deep_powerdown_state;

   // Receive capture: even half at the falling receive edge, odd half at the rising one.
   logic [chpx_pkg::WORD_W-1:0] hold_even;
   logic [chpx_pkg::ROW_W+chpx_pkg::COL_W-1:0] hold_req;
   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_even <= '0;
         hold_req <= '0;
         rx_data_even <= '0;
         rx_data_odd <= '0;
         rx_req_pair <= '0;
         rx_pair_valid <= 1'b0;
      end else if (ce) begin
         rx_pair_valid <= 1'b0;
         if (rx_fall) begin
            hold_even <= {bus_b, bus_a};
            hold_req <= {col_s, row_s};
         end
         if (rx_rise) begin
            rx_data_even <= hold_even;
            rx_data_odd <= {bus_b, bus_a};
            rx_req_pair <= {col_s, row_s, hold_req};
            rx_pair_valid <= 1'b1;
         end
      end
   end

   // Initialization latch; once locked, later loads are ignored so the return timing never moves.
   chpx_pkg::chpx_cfg_e cfg_state;
   logic [chpx_pkg::LAT_W-1:0] lat;
   logic [1:0] adj;
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_state <= chpx_pkg::CHPX_CFG_OPEN;
         lat <= chpx_pkg::LAT_RESET;
         adj <= chpx_pkg::ADJ_NOMINAL;
      end else if (ce) begin
         case (cfg_state)
            chpx_pkg::CHPX_CFG_OPEN: begin
               if (cfg_load) begin
                  lat <= (cfg_latency < chpx_pkg::LAT_MIN) ? chpx_pkg::LAT_MIN :
                         (cfg_latency > chpx_pkg::LAT_MAX) ? chpx_pkg::LAT_MAX : cfg_latency;
                  adj <= (cfg_adjust == chpx_pkg::ADJ_LATE || cfg_adjust == chpx_pkg::ADJ_EARLY) ?
                         cfg_adjust : chpx_pkg::ADJ_NOMINAL;
                  cfg_state <= chpx_pkg::CHPX_CFG_LOCKED;
               end
            end
            chpx_pkg::CHPX_CFG_LOCKED: cfg_state <= chpx_pkg::CHPX_CFG_LOCKED;
            default: cfg_state <= chpx_pkg::CHPX_CFG_OPEN;
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) cfg_locked <= 1'b0;
      else if (ce) cfg_locked <= (cfg_state == chpx_pkg::CHPX_CFG_LOCKED);
   end

   // Receive-clock countdown before handing to the transmit side; the final hop is a transmit edge.
   function automatic logic [chpx_pkg::CNT_W-1:0] eff_delay(input logic [chpx_pkg::LAT_W-1:0] l,
                                                             input logic [1:0] a);
      logic [chpx_pkg::CNT_W-1:0] base;
      base = {1'b0, l} - 5'h01;
      case (a)
         chpx_pkg::ADJ_EARLY: eff_delay = base - 5'h01;
         chpx_pkg::ADJ_LATE: eff_delay = base + 5'h01;
         default: eff_delay = base;
      endcase
   endfunction : eff_delay

   logic [chpx_pkg::QDEPTH-1:0] q_valid;
   logic [chpx_pkg::CNT_W-1:0] q_cnt [chpx_pkg::QDEPTH];
   logic [chpx_pkg::WORD_W-1:0] q_even [chpx_pkg::QDEPTH];
   logic [chpx_pkg::WORD_W-1:0] q_odd [chpx_pkg::QDEPTH];
   logic [chpx_pkg::QPTR_W-1:0] wp, rp;
   logic head_ready, take;
   chpx_pkg::chpx_tx_e tx_state;

   assign head_ready = q_valid[rp] && (q_cnt[rp] == '0);
   assign take = tx_rise && head_ready &&
                 (tx_state == chpx_pkg::CHPX_TX_IDLE || tx_state == chpx_pkg::CHPX_TX_ODD_HOLD);

   genvar gi;
   generate
      for (gi = 0; gi < chpx_pkg::QDEPTH; gi++) begin : g_q
         always_ff @(posedge mclk) begin
            if (rst) begin
               q_valid[gi] <= 1'b0;
               q_cnt[gi] <= '0;
               q_even[gi] <= '0;
               q_odd[gi] <= '0;
            end else if (ce) begin
               if (rd_cmd && wp == chpx_pkg::QPTR_W'(gi)) begin
                  q_valid[gi] <= 1'b1;
                  q_cnt[gi] <= eff_delay(lat, adj);
                  q_even[gi] <= rd_even;
                  q_odd[gi] <= rd_odd;
               end else if (take && rp == chpx_pkg::QPTR_W'(gi)) begin
                  q_valid[gi] <= 1'b0;
               end else if (rx_fall && q_valid[gi] && q_cnt[gi] != '0) begin
                  q_cnt[gi] <= q_cnt[gi] - 5'h01;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
      end else if (ce) begin
         if (rd_cmd) wp <= wp + 2'h1;
         if (take) rp <= rp + 2'h1;
      end
   end

   // Transmit low-phase measurement gives the quarter-cycle offset for the drive points.
   logic [chpx_pkg::HALF_W-1:0] half_cnt, half_len, qtimer;
   logic [chpx_pkg::HALF_W-1:0] quarter;
   assign quarter = (half_len[chpx_pkg::HALF_W-1:1] == '0) ? 6'h01 : {1'b0, half_len[chpx_pkg::HALF_W-1:1]};
   always_ff @(posedge mclk) begin
      if (rst) begin
         half_cnt <= '0;
         half_len <= chpx_pkg::HALF_RESET;
      end else if (ce) begin
         if (tx_fall) half_cnt <= 6'h01;
         else if (half_cnt != '1) half_cnt <= half_cnt + 6'h01;
         if (tx_rise) half_len <= half_cnt;
      end
   end

   // Transmit sequencer, timed only from transmit clock edges.
   logic [chpx_pkg::WORD_W-1:0] st_even, st_odd;
   logic st_valid;
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_state <= chpx_pkg::CHPX_TX_IDLE;
         st_even <= '0;
         st_odd <= '0;
         st_valid <= 1'b0;
         qtimer <= '0;
         data_byte_bus_a_out <= '0;
         data_byte_bus_b_out <= '0;
         data_bus_oe <= 1'b0;
      end else if (ce) begin
         if (qtimer != '0) qtimer <= qtimer - 6'h01;
         case (tx_state)
            chpx_pkg::CHPX_TX_IDLE, chpx_pkg::CHPX_TX_ODD_HOLD: begin
               if (tx_rise) begin
                  st_valid <= head_ready;
                  st_even <= q_even[rp];
                  st_odd <= q_odd[rp];
                  qtimer <= quarter;
                  tx_state <= (head_ready || tx_state == chpx_pkg::CHPX_TX_ODD_HOLD) ?
                              chpx_pkg::CHPX_TX_EVEN_WAIT : chpx_pkg::CHPX_TX_IDLE;
               end
            end
            chpx_pkg::CHPX_TX_EVEN_WAIT: begin
               if (qtimer == 6'h01 || qtimer == '0) begin
                  if (st_valid) begin
                     {data_byte_bus_b_out, data_byte_bus_a_out} <= st_even;
                     data_bus_oe <= 1'b1;
                     tx_state <= chpx_pkg::CHPX_TX_ODD_WAIT;
                  end else begin
                     data_bus_oe <= 1'b0;
                     tx_state <= chpx_pkg::CHPX_TX_IDLE;
                  end
               end
            end
            chpx_pkg::CHPX_TX_ODD_WAIT: begin
               if (tx_fall) begin
                  qtimer <= quarter;
                  tx_state <= chpx_pkg::CHPX_TX_ODD_DLY;
               end
            end
            chpx_pkg::CHPX_TX_ODD_DLY: begin
               if (qtimer == 6'h01 || qtimer == '0) begin
                  {data_byte_bus_b_out, data_byte_bus_a_out} <= st_odd;
                  tx_state <= chpx_pkg::CHPX_TX_ODD_HOLD;
               end
            end
            default: tx_state <= chpx_pkg::CHPX_TX_IDLE;
         endcase
      end
   end

   // Serial port: command pairs, data input, read output and the daisy chain.
   logic cmd_odd;
   logic [chpx_pkg::ID_W-1:0] dev_id;
   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_odd <= 1'b0;
         serial_cmd_bits <= '0;
         serial_cmd_valid <= 1'b0;
         sio_rx_bit <= 1'b0;
         sio_rx_valid <= 1'b0;
      end else if (ce) begin
         serial_cmd_valid <= 1'b0;
         sio_rx_valid <= 1'b0;
         if (sck_rise) cmd_odd <= cmd_s;
         if (sck_fall) begin
            serial_cmd_bits <= {cmd_odd, cmd_s};
            serial_cmd_valid <= 1'b1;
            sio_rx_bit <= first_s;
            sio_rx_valid <= 1'b1;
         end
      end
   end

   // The chain is relayed every master clock rather than on serial clock edges.
   always_ff @(posedge mclk) begin
      if (rst) begin
         serial_chain_port_first_out <= 1'b0;
         serial_chain_port_first_oe <= 1'b0;
         serial_chain_port_second_out <= 1'b0;
         serial_chain_port_second_oe <= 1'b0;
      end else if (ce) begin
         serial_chain_port_second_out <= first_s;
         serial_chain_port_second_oe <= ~sio_read_phase;
         serial_chain_port_first_oe <= sio_read_phase;
         if (!sio_tx_en) serial_chain_port_first_out <= second_s;
         else if (sck_fall) serial_chain_port_first_out <= sio_tx_bit;
      end
   end

   // Wake request: cmd high at a rising serial edge while asleep.
   always_ff @(posedge mclk) begin
      if (rst) begin
         dev_id <= device_id_strap;
         wake_start <= 1'b0;
      end else if (ce) begin
         wake_start <= sck_rise && cmd_s && asleep &&
                       (broadcast_wake_select || bus_a[chpx_pkg::ID_W-1:0] == dev_id);
      end
   end

   property p_rx_even;
      @(posedge mclk) disable iff (rst || !ce) rx_fall |=> hold_even == $past({bus_b, bus_a});
   endproperty
   a_rx_even: assert property (p_rx_even) else $error("even capture not taken at falling edge");
   property p_rx_pair;
      @(posedge mclk) disable iff (rst || !ce) rx_rise |=> rx_pair_valid && rx_data_even == $past(hold_even);
   endproperty
   a_rx_pair: assert property (p_rx_pair) else $error("pair not delivered at rising edge");
   property p_cfg_fixed;
      @(posedge mclk) disable iff (rst || !ce) cfg_locked |=> cfg_locked && $stable(lat) && $stable(adj);
   endproperty
   a_cfg_fixed: assert property (p_cfg_fixed) else $error("delay choice changed after lock");
   property p_lat_range;
      @(posedge mclk) disable iff (rst) lat >= chpx_pkg::LAT_MIN && lat <= chpx_pkg::LAT_MAX;
   endproperty
   a_lat_range: assert property (p_lat_range) else $error("latency outside 8..12");
   property p_load_cnt;
      @(posedge mclk) disable iff (rst || !ce) rd_cmd |=> q_cnt[$past(wp)] ==
         {1'b0, lat} - ((adj == chpx_pkg::ADJ_EARLY) ? 5'h02 : 5'h01) + ((adj == chpx_pkg::ADJ_LATE) ? 5'h01 : 5'h00);
   endproperty
   a_load_cnt: assert property (p_load_cnt) else $error("read countdown loaded wrong");
   property p_even_drive;
      @(posedge mclk) disable iff (rst || !ce)
         (tx_state == chpx_pkg::CHPX_TX_EVEN_WAIT && qtimer == 6'h01 && st_valid) |=>
            data_bus_oe && {data_byte_bus_b_out, data_byte_bus_a_out} == $past(st_even);
   endproperty
   a_even_drive: assert property (p_even_drive) else $error("even bit not driven");
   property p_oe_from_tx;
      @(posedge mclk) disable iff (rst || !ce) $rose(data_bus_oe) |-> $past(tx_state == chpx_pkg::CHPX_TX_EVEN_WAIT);
   endproperty
   a_oe_from_tx: assert property (p_oe_from_tx) else $error("drive not timed from transmit clock");
   property p_cmd;
      @(posedge mclk) disable iff (rst || !ce)
         sck_fall |=> serial_cmd_valid && serial_cmd_bits == {$past(cmd_odd), $past(cmd_s)};
   endproperty
   a_cmd: assert property (p_cmd) else $error("command pair wrong");
   property p_sdin;
      @(posedge mclk) disable iff (rst || !ce) sck_fall |=> sio_rx_valid && sio_rx_bit == $past(first_s);
   endproperty
   a_sdin: assert property (p_sdin) else $error("serial input not sampled at falling edge");
   property p_sdout;
      @(posedge mclk) disable iff (rst || !ce)
         (sio_tx_en && !sck_fall) |=> $stable(serial_chain_port_first_out);
   endproperty
   a_sdout: assert property (p_sdout) else $error("serial output moved off the falling edge");
   property p_relay;
      @(posedge mclk) disable iff (rst || !ce) !sio_read_phase |=> serial_chain_port_second_oe &&
         serial_chain_port_second_out == $past(first_s);
   endproperty
   a_relay: assert property (p_relay) else $error("chain relay broken");
   property p_bcast;
      @(posedge mclk) disable iff (rst || !ce)
         (sck_rise && cmd_s && asleep && broadcast_wake_select) |=> wake_start;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast wake missed");
   property p_directed;
      @(posedge mclk) disable iff (rst || !ce)
         (!broadcast_wake_select && bus_a[chpx_pkg::ID_W-1:0] != dev_id) |=> !wake_start;
   endproperty
   a_directed: assert property (p_directed) else $error("wrong device woke");
   c_read: cover property (@(posedge mclk) disable iff (rst) take);
   c_odd: cover property (@(posedge mclk) disable iff (rst) tx_state == chpx_pkg::CHPX_TX_ODD_HOLD);
   c_wake: cover property (@(posedge mclk) disable iff (rst) wake_start);
endmodule : chpx_top

// ===== test/chpx_ctrl_model.sv
// Controller-side model that makes the channel clocks and a framed serial clock.
module chpx_ctrl_model #(
   parameter int PHASE_NS = 50
) (
   // Serial frame control
   input wire logic sck_en,
   // Clocks towards the device
   output logic transmit_clock_true,
   output logic receive_clock_true,
   output logic serial_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      transmit_clock_true = 1'b1;
      receive_clock_true = 1'b1;
      serial_clock = 1'b0;
   end
   always #200 transmit_clock_true = ~transmit_clock_true;
   // The receive pair starts late so the transmit pair always leads it.
   initial begin
      #PHASE_NS;
      forever #200 receive_clock_true = ~receive_clock_true;
   end
   // The serial clock rests low between frames, so no stray edge is seen.
   always #200 serial_clock = sck_en ? ~serial_clock : 1'b0;
endmodule : chpx_ctrl_model

// ===== test/testbench.sv
// Self-checking bench for the channel phasing and read crossing block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst = 1'b1, sck_en = 1'b0, wake_seen = 1'b0, ce = 1'b1;
   logic txc, rxc, sck, oe, pv, locked, f_out, f_oe, s_out, s_oe, cval, rxb, rxv, wake;
   logic [8:0] da = 9'h000, db = 9'h000, qa, qb;
   logic [2:0] row = 3'h0;
   logic [4:0] col = 5'h00;
   logic [17:0] ev, od, rd_even = 18'h2a5a5, rd_odd = 18'h15a5a;
   logic [15:0] req;
   logic [1:0] cbits, cfg_adj = 2'h0, pwr = 2'h0;
   logic [3:0] cfg_lat = 4'h8;
   logic rd_cmd = 1'b0, cfg_load = 1'b0, cmd = 1'b0, f_in = 1'b0, s_in = 1'b0;
   logic rphase = 1'b0, tx_bit = 1'b0, tx_en = 1'b0, bcast = 1'b0;
   int bad_count = 0, num_checks = 0, ticks = 0;
   int t[5];
   chpx_ctrl_model i_ctrl (.sck_en(sck_en), .transmit_clock_true(txc), .receive_clock_true(rxc), .serial_clock(sck));
   chpx_top i_dut (
      .mclk(mclk), .rst(rst), .ce(ce), .transmit_clock_true(txc), .receive_clock_true(rxc),
      .data_byte_bus_a_in(da), .data_byte_bus_a_out(qa), .data_byte_bus_b_in(db), .data_byte_bus_b_out(qb),
      .data_bus_oe(oe), .row_bus(row), .col_bus(col), .rx_data_even(ev), .rx_data_odd(od), .rx_req_pair(req),
      .rx_pair_valid(pv), .rd_cmd(rd_cmd), .rd_even(rd_even), .rd_odd(rd_odd), .cfg_load(cfg_load),
      .cfg_latency(cfg_lat), .cfg_adjust(cfg_adj), .cfg_locked(locked), .serial_clock(sck), .serial_cmd(cmd),
      .serial_chain_port_first_in(f_in), .serial_chain_port_first_out(f_out), .serial_chain_port_first_oe(f_oe),
      .serial_chain_port_second_in(s_in), .serial_chain_port_second_out(s_out),
      .serial_chain_port_second_oe(s_oe), .sio_read_phase(rphase), .sio_tx_bit(tx_bit), .sio_tx_en(tx_en),
      .serial_cmd_bits(cbits), .serial_cmd_valid(cval), .sio_rx_bit(rxb), .sio_rx_valid(rxv),
      .light_sleep_state(pwr[0]), .deep_powerdown_state(pwr[1]), .broadcast_wake_select(bcast),
      .device_id_strap(6'h2d), .wake_start(wake));
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      ticks++;
      if (wake === 1'b1) wake_seen = 1'b1;
      if (ticks == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask : tick
   task automatic wait_for(ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
      check("pulse wait", 32'(n < lim), 32'h1);
   endtask : wait_for
   task automatic do_reset(input logic [3:0] lat, input logic [1:0] adj);
      rst = 1'b1;
      tick(5);
      rst = 1'b0;
      tick(1);
      check("oe after reset", oe, 1'b0);
      check("lock after reset", locked, 1'b0);
      cfg_lat = lat;
      cfg_adj = adj;
      cfg_load = 1'b1;
      tick(1);
      cfg_load = 1'b0;
      tick(1);
      check("locked", locked, 1'b1);
   endtask : do_reset
   task automatic rx_pair(input logic [17:0] e, input logic [17:0] o, input logic [7:0] er, input logic [7:0] orq);
      @(posedge rxc);
      tick(4);
      {db, da} = e;
      {col, row} = er;
      @(negedge rxc);
      tick(4);
      {db, da} = o;
      {col, row} = orq;
      wait_for(pv, 20);
      check("even pair", ev, e);
      check("odd pair", od, o);
      check("request pair", req, {orq, er});
   endtask : rx_pair
   // The command is issued at a fixed phase of the receive clock so intervals compare exactly.
   task automatic rd_time(output int n);
      @(negedge rxc);
      tick(1);
      rd_cmd = 1'b1;
      tick(1);
      rd_cmd = 1'b0;
      n = 1;
      while (oe !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      check("even word", {qb, qa}, rd_even);
      repeat (12) if ({qb, qa} === rd_even) tick(1);
      check("odd word", {qb, qa}, rd_odd);
      repeat (12) if (oe === 1'b1) tick(1);
      check("bus release", oe, 1'b0);
   endtask : rd_time
   task automatic sck_cycle(input logic cf);
      sck_en = 1'b1;
      @(posedge sck);
      tick(2);
      cmd = cf;
      @(negedge sck);
      tick(1);
      sck_en = 1'b0;
   endtask : sck_cycle
   task automatic ser_bits(input logic cr, input logic cf, input logic din);
      cmd = cr;
      f_in = din;
      sck_cycle(cf);
      wait_for(cval, 8);
      check("command pair", cbits, {cr, cf});
      check("serial input", {rxv, rxb}, {1'b1, din});
   endtask : ser_bits
   task automatic wake_try(input logic [1:0] p, input logic bc, input logic [5:0] id, input logic exp);
      pwr = p;
      bcast = bc;
      da = {3'h0, id};
      wake_seen = 1'b0;
      ser_bits(1'b1, 1'b0, 1'b0);
      tick(4);
      check("wake", wake_seen, exp);
   endtask : wake_try
   task automatic chain_test();
      rphase = 1'b0;
      f_in = 1'b1;
      tick(6);
      check("relay down", {s_oe, f_oe, s_out}, 3'h5);
      f_in = 1'b0;
      tick(6);
      check("relay down low", s_out, 1'b0);
      ce = 1'b0;
      f_in = 1'b1;
      tick(6);
      check("relay frozen", s_out, 1'b0);
      ce = 1'b1;
      rphase = 1'b1;
      s_in = 1'b1;
      tick(6);
      check("relay back", {s_oe, f_oe, f_out}, 3'h3);
      tx_en = 1'b1;
      sck_cycle(1'b0);
      tick(5);
      check("own bit", f_out, 1'b0);
      tx_bit = 1'b1;
      tick(10);
      check("own bit held", f_out, 1'b0);
      sck_cycle(1'b0);
      tick(5);
      check("own bit next", f_out, 1'b1);
      tx_en = 1'b0;
      rphase = 1'b0;
   endtask : chain_test
   initial begin
      do_reset(4'h8, chpx_pkg::ADJ_NOMINAL);
      rx_pair(18'h3fe01, 18'h001fe, 8'ha5, 8'h5a);
      rx_pair(18'h00000, 18'h3ffff, 8'hff, 8'h00);
      rd_time(t[0]);
      do_reset(4'h8, chpx_pkg::ADJ_EARLY);
      rd_time(t[1]);
      do_reset(4'h8, chpx_pkg::ADJ_LATE);
      rd_time(t[2]);
      do_reset(4'hc, chpx_pkg::ADJ_NOMINAL);
      rd_time(t[3]);
      cfg_adj = chpx_pkg::ADJ_EARLY;
      cfg_lat = 4'h8;
      cfg_load = 1'b1;
      tick(1);
      cfg_load = 1'b0;
      rd_time(t[4]);
      check("early gap", 32'(t[0] - t[1]), 32'h8);
      check("late gap", 32'(t[2] - t[0]), 32'h8);
      check("latency span", 32'(t[3] - t[0]), 32'h20);
      check("locked choice", 32'(t[4]), 32'(t[3]));
      ser_bits(1'b1, 1'b0, 1'b1);
      ser_bits(1'b0, 1'b1, 1'b0);
      chain_test();
      wake_try(2'h1, 1'b1, 6'h00, 1'b1);
      wake_try(2'h2, 1'b1, 6'h3f, 1'b1);
      wake_try(2'h2, 1'b0, 6'h2d, 1'b1);
      wake_try(2'h1, 1'b0, 6'h2c, 1'b0);
      wake_try(2'h0, 1'b1, 6'h2d, 1'b0);
      close_out();
   end
endmodule : testbench
